// ### src/bsrx_top.v
// Purpose: Receive control of one byte-sync serial channel.
// Assumes: One clock; rx_bit_stb marks each serial bit, LSB first.
// Notes: Characters go to a FIFO drained by the CPU or a DMA engine.
//
// Summary of operation
// - First-character mode interrupts on first data only
// - Special receive conditions still interrupt during DMA
// - Status modifies vector only in channel B
// - Enable-next-character command re-arms first-character mode
// - Hunt ends after two contiguous sync characters
// - Ready goes active when a byte is available
// - Overrun errors interrupt, CRC errors only set status; host clears and restarts
// - Overrun interrupts and stays latched until an error reset
// - CRC status valid sixteen bit times later
//
// Local design decisions: the address-and-strobe port and the register addresses.

`include "bsrx_map.vh"

////////////////////////////////////////////////////////////////////////
// Character FIFO with valid/ready on both sides.
module bsrx_fifo #(
	parameter W = 8,
	parameter D = 32,
	parameter AW = 5
) (
	input wire clk,
	input wire reset_n,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1]; // Storage, no reset needed.
	reg [AW-1:0] wp_q, rp_q; // Write and read pointers.
	reg [AW:0] cnt_q; // Number of words held.
	wire push, pop; // Handshakes that both sides complete.

	assign in_ready = (cnt_q != D[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem[rp_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage write; the array is kept out of reset to stay a RAM.
	always @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	// Pointers and count; a flush drops everything held.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (flush) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
// Receive control top.
module bsrx_top #(
	parameter CHANNEL_B = 1'b1
) (
	input wire clk,
	input wire reset_n,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr_stb,
	input wire rd_stb,
	output reg [7:0] rdata_q,
	input wire rx_data,
	input wire rx_bit_stb,
	input wire dcd_n,
	input wire dma_rd_stb,
	output reg [7:0] dma_data_q,
	output reg rdy_n_q,
	output reg irq_n_q
);
	// Character length from the two-bit field: 00=5 10=6 01=7 11=8.
	function [3:0] bsrx_len;
		input [1:0] f;
		begin
			case (f)
			2'b00: bsrx_len = 4'd5;
			2'b10: bsrx_len = 4'd6;
			2'b01: bsrx_len = 4'd7;
			default: bsrx_len = 4'd8;
			endcase
		end
	endfunction

	reg [7:0] imr_q; // Interrupt mode register.
	reg [7:0] rcr_q; // Receive configuration register.
	reg [7:0] vec_q; // Interrupt vector.
	reg [7:0] syn1_q; // First sync character.
	reg [7:0] syn2_q; // Second sync character.
	reg [15:0] sh_q; // Serial window, newest bit at the top.
	reg hunt_q; // High while searching for sync.
	reg [3:0] bitcnt_q; // Bits of the current character.
	reg started_q; // A data character was seen in this message.
	reg armed_q; // First-character interrupt is armed.
	reg rxint_q; // Receive character interrupt pending.
	reg ovr_q; // Latched overrun.
	reg ext_q; // External status change pending.
	reg dcd_prev_q; // Last sampled carrier level.
	reg [15:0] crc_q; // CRC checker.
	reg [7:0] pend_q; // Last character, awaiting CRC decision.
	reg pend_v_q; // Pending character is valid.
	reg [7:0] cshift_q; // Bits still to shift into the CRC.
	reg [3:0] ccnt_q; // Shifts left.
	reg crc_err_q; // CRC comparison result.

	wire [15:0] sh_d, crc_d;
	wire [3:0] len;
	wire [7:0] chr, fifo_head;
	wire [2:0] cmd, cause;
	wire [1:0] mode;
	wire rx_on, bit_in, chr_done, is_strip, fifo_rdy, fifo_val;
	wire cpu_pop, pop, cmd_wr, crc_fb, spc_int;

	assign mode = imr_q[`BSRX_IMR_MODE_LSB+1:`BSRX_IMR_MODE_LSB];
	assign len = bsrx_len(rcr_q[`BSRX_RCR_LEN_LSB+1:`BSRX_RCR_LEN_LSB]);
	// Auto enables hold the receiver off until carrier is present.
	assign rx_on = rcr_q[`BSRX_RCR_EN] &&
		(!rcr_q[`BSRX_RCR_AUTO] || !dcd_n);
	assign bit_in = rx_bit_stb && rx_on;
	assign sh_d = {rx_data, sh_q[15:1]};
	assign chr = sh_d[15:8] >> (4'd8 - len);
	assign chr_done = bit_in && !hunt_q && (bitcnt_q + 4'd1 == len);
	// Leading copies of the first sync character are stripped when load inhibit is set.
	assign is_strip = rcr_q[`BSRX_RCR_SLI] && !started_q &&
		(chr == (syn1_q >> (4'd8 - len)));
	assign cmd_wr = wr_stb && (addr == `BSRX_A_CMD);
	assign cmd = wdata[`BSRX_CMD_LSB+2:`BSRX_CMD_LSB];
	assign cpu_pop = rd_stb && (addr == `BSRX_A_DATA);
	assign pop = (cpu_pop || dma_rd_stb) && fifo_val;
	assign crc_fb = cshift_q[0] ^ crc_q[0];
	assign crc_d = (bit_in && (ccnt_q != 4'h0)) ?
		((crc_q >> 1) ^ (crc_fb ? `BSRX_CRC_POLY : 16'h0000)) : crc_q;
	assign spc_int = ovr_q && (mode != `BSRX_MODE_OFF);

	// Cause code, highest priority first.
	assign cause = spc_int ? `BSRX_V_SPC :
		rxint_q ? `BSRX_V_RXC :
		(ext_q && imr_q[`BSRX_IMR_EXT_EN]) ? `BSRX_V_EXT : `BSRX_V_NONE;

	////////////////////////////////////////////////////////////////
	// The FIFO sits between the character assembler and the readers.
	bsrx_fifo #(
		.W(8),
		.D(32),
		.AW(5)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.flush(cmd_wr && (cmd == `BSRX_CMD_CH_RST)),
		.in_valid(chr_done && !is_strip),
		.in_ready(fifo_rdy),
		.in_data(chr),
		.out_valid(fifo_val),
		.out_ready(cpu_pop || dma_rd_stb),
		.out_data(fifo_head)
	);

	////////////////////////////////////////////////////////////////
	// Software registers written from the register port.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			imr_q <= `BSRX_RST_BYTE;
			rcr_q <= `BSRX_RST_BYTE;
			vec_q <= `BSRX_RST_BYTE;
			syn1_q <= `BSRX_RST_BYTE;
			syn2_q <= `BSRX_RST_BYTE;
		end else if (cmd_wr && (cmd == `BSRX_CMD_CH_RST)) begin
			// Channel reset leaves the receiver and interrupts off.
			imr_q <= `BSRX_RST_BYTE;
			rcr_q <= `BSRX_RST_BYTE;
		end else if (wr_stb) begin
			if (addr == `BSRX_A_IMR) begin
				imr_q <= wdata;
			end else if (addr == `BSRX_A_VEC) begin
				vec_q <= wdata;
			end else if (addr == `BSRX_A_RCR) begin
				rcr_q <= wdata;
			end else if (addr == `BSRX_A_SYN1) begin
				syn1_q <= wdata;
			end else if (addr == `BSRX_A_SYN2) begin
				syn2_q <= wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Hunt and character assembly.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sh_q <= 16'h0000;
			hunt_q <= 1'b1;
			bitcnt_q <= 4'h0;
			started_q <= 1'b0;
		end else begin
			if (bit_in) begin
				sh_q <= sh_d;
			end
			if ((wr_stb && (addr == `BSRX_A_RCR) &&
				wdata[`BSRX_RCR_HUNT]) ||
				(cmd_wr && (cmd == `BSRX_CMD_CH_RST))) begin
				// Entering hunt restarts the message.
				hunt_q <= 1'b1;
				started_q <= 1'b0;
				bitcnt_q <= 4'h0;
			end else if (bit_in && hunt_q) begin
				// Both sync characters must sit back to back.
				if (sh_d == {syn2_q, syn1_q}) begin
					hunt_q <= 1'b0;
					bitcnt_q <= 4'h0;
				end
			end else if (chr_done) begin
				bitcnt_q <= 4'h0;
				if (!is_strip) begin
					started_q <= 1'b1;
				end
			end else if (bit_in) begin
				bitcnt_q <= bitcnt_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt sources; a set in the clearing cycle wins.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			armed_q <= 1'b1;
			rxint_q <= 1'b0;
			ovr_q <= 1'b0;
			ext_q <= 1'b0;
			dcd_prev_q <= 1'b1;
		end else begin
			dcd_prev_q <= dcd_n;
			// A CPU read of the data register satisfies its interrupt.
			if (chr_done && !is_strip && (mode == `BSRX_MODE_FIRST) &&
				armed_q) begin
				rxint_q <= 1'b1;
			end else if (chr_done && !is_strip && mode[1]) begin
				rxint_q <= 1'b1;
			end else if (cpu_pop) begin
				rxint_q <= 1'b0;
			end
			// In first-character mode only the first character after each arming interrupts.
			if (cmd_wr && (cmd == `BSRX_CMD_EN_NEXT)) begin
				armed_q <= 1'b1;
			end else if (chr_done && !is_strip &&
				(mode == `BSRX_MODE_FIRST)) begin
				armed_q <= 1'b0;
			end
			// A full FIFO loses the character and latches overrun.
			if (chr_done && !is_strip && !fifo_rdy) begin
				ovr_q <= 1'b1;
			end else if (cmd_wr && (cmd == `BSRX_CMD_ERR_RST)) begin
				ovr_q <= 1'b0;
			end
			if ((dcd_n != dcd_prev_q) && imr_q[`BSRX_IMR_EXT_EN]) begin
				ext_q <= 1'b1;
			end else if (cmd_wr && ((cmd == `BSRX_CMD_RST_EXT) ||
				(cmd == `BSRX_CMD_CH_RST))) begin
				ext_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// CRC: each character is judged at the next transfer, then shifted
	// over the following eight bit times, so the result lags sixteen.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			crc_q <= `BSRX_CRC_INIT;
			pend_q <= 8'h00;
			pend_v_q <= 1'b0;
			cshift_q <= 8'h00;
			ccnt_q <= 4'h0;
			crc_err_q <= 1'b0;
		end else if (cmd_wr && (wdata[7:6] == `BSRX_CRC_RST)) begin
			crc_q <= `BSRX_CRC_INIT;
			ccnt_q <= 4'h0;
			pend_v_q <= 1'b0;
		end else begin
			if (bit_in && (ccnt_q != 4'h0)) begin
				cshift_q <= {1'b0, cshift_q[7:1]};
				ccnt_q <= ccnt_q - 4'h1;
				crc_q <= crc_d; // Last shift may share the transfer edge.
			end
			if (chr_done && !is_strip) begin
				pend_q <= chr;
				pend_v_q <= 1'b1;
				crc_err_q <= (crc_d != 16'h0000);
				if (pend_v_q && rcr_q[`BSRX_RCR_CRC]) begin
					cshift_q <= pend_q;
					ccnt_q <= `BSRX_CRC_SHIFTS;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port, DMA data, ready and interrupt outputs.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
			dma_data_q <= 8'h00;
			rdy_n_q <= 1'b1;
			irq_n_q <= 1'b1;
		end else begin
			// Ready follows the FIFO; it goes inactive at the edge of each pop for one cycle.
			rdy_n_q <= !(imr_q[`BSRX_IMR_WR_EN] && fifo_val &&
				!pop);
			irq_n_q <= !(rxint_q || spc_int ||
				(ext_q && imr_q[`BSRX_IMR_EXT_EN]));
			if (dma_rd_stb) begin
				dma_data_q <= fifo_val ? fifo_head : 8'h00;
			end
			if (!rd_stb) begin
				rdata_q <= 8'h00;
			end else if (addr == `BSRX_A_CMD) begin
				rdata_q <= {3'h0, hunt_q, !dcd_prev_q, 1'b0,
					!irq_n_q, fifo_val};
			end else if (addr == `BSRX_A_IMR) begin
				rdata_q <= {1'b0, crc_err_q, ovr_q, 5'h00};
			end else if (addr == `BSRX_A_VEC) begin
				// Only channel B lets the cause alter the vector.
				if (CHANNEL_B && imr_q[`BSRX_IMR_SAV]) begin
					rdata_q <= {vec_q[7:4], cause, vec_q[0]};
				end else begin
					rdata_q <= vec_q;
				end
			end else if (addr == `BSRX_A_RCR) begin
				rdata_q <= rcr_q;
			end else if (addr == `BSRX_A_DATA) begin
				rdata_q <= fifo_val ? fifo_head : 8'h00;
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end
endmodule

// ### src/bsrx_map.vh
// Purpose: Constants for the byte-sync receive control block.
// Assumes: Included by bsrx_top.v only.
// Notes: Offsets are word indices on the plain register port.
`ifndef BSRX_MAP_VH
`define BSRX_MAP_VH
// Register offsets.
`define BSRX_A_CMD 4'h0
`define BSRX_A_IMR 4'h1
`define BSRX_A_VEC 4'h2
`define BSRX_A_RCR 4'h3
`define BSRX_A_SYN1 4'h6
`define BSRX_A_SYN2 4'h7
`define BSRX_A_DATA 4'h8
// Command field of the command/pointer register.
`define BSRX_CMD_LSB 3
`define BSRX_CMD_RST_EXT 3'h2
`define BSRX_CMD_CH_RST 3'h3
`define BSRX_CMD_EN_NEXT 3'h4
`define BSRX_CMD_ERR_RST 3'h6
`define BSRX_CRC_RST 2'h1
// Interrupt mode register fields.
`define BSRX_IMR_EXT_EN 0
`define BSRX_IMR_SAV 2
`define BSRX_IMR_MODE_LSB 3
`define BSRX_MODE_OFF 2'h0
`define BSRX_MODE_FIRST 2'h1
`define BSRX_IMR_WR_EN 7
// Receive configuration register fields.
`define BSRX_RCR_EN 0
`define BSRX_RCR_SLI 1
`define BSRX_RCR_CRC 3
`define BSRX_RCR_HUNT 4
`define BSRX_RCR_AUTO 5
`define BSRX_RCR_LEN_LSB 6
// Receive condition status bits.
`define BSRX_ST_OVR 5
`define BSRX_ST_CRC 6
// Vector cause codes.
`define BSRX_V_NONE 3'h3
`define BSRX_V_EXT 3'h5
`define BSRX_V_RXC 3'h6
`define BSRX_V_SPC 3'h7
// Reset values and timing in bit times.
`define BSRX_RST_BYTE 8'h00
`define BSRX_CRC_INIT 16'h0000
`define BSRX_CRC_POLY 16'ha001
`define BSRX_CRC_SHIFTS 4'h8
`endif

// ### tb/bsrx_top_asserts.sv
// Purpose: Port-level checks for the byte-sync receive control.
// Assumes: One clock domain; reset_n is asynchronous and active low.
// Notes: Bound to bsrx_top from the bench's top file.
module bsrx_top_asserts (
	input wire clk,
	input wire reset_n,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr_stb,
	input wire rd_stb,
	input wire [7:0] rdata_q,
	input wire rx_data,
	input wire rx_bit_stb,
	input wire dcd_n,
	input wire dma_rd_stb,
	input wire [7:0] dma_data_q,
	input wire rdy_n_q,
	input wire irq_n_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Any host access now or last cycle may legally change state.
	sequence host_quiet;
		!rd_stb && !wr_stb && !$past(rd_stb) && !$past(wr_stb);
	endsequence
	// An interrupt needs a recent serial bit, carrier change or write.
	sequence irq_cause;
		$past(rx_bit_stb) || $past(rx_bit_stb, 2) || $past(wr_stb, 2) ||
		$past(dcd_n) != $past(dcd_n, 2) || $past(dcd_n, 2) != $past(dcd_n, 3);
	endsequence
	a_reset_idle: assert property ($rose(reset_n) |-> rdy_n_q && irq_n_q)
		else $error("outputs not idle after reset");
	a_rdata_idle: assert property (!$past(rd_stb) |-> rdata_q == 8'h00)
		else $error("read data without a read");
	a_unmapped_rd: assert property (rd_stb && addr == 4'h5 |=> rdata_q == 8'h00)
		else $error("unmapped read not zero");
	a_dma_hold: assert property (!$past(dma_rd_stb) |-> $stable(dma_data_q))
		else $error("dma data moved without a pop");
	a_rdy_after_pop: assert property (dma_rd_stb |=> rdy_n_q)
		else $error("ready stayed active over a pop");
	a_rdy_hold: assert property (!rdy_n_q ##0 host_quiet ##0 !dma_rd_stb
		|=> !rdy_n_q)
		else $error("ready dropped with data left");
	a_irq_hold: assert property (!irq_n_q ##0 host_quiet |=> !irq_n_q)
		else $error("interrupt cleared without host action");
	a_irq_cause: assert property ($fell(irq_n_q) |-> irq_cause)
		else $error("interrupt without a cause");
endmodule

// ### tb/bsrx_line.sv
// Purpose: Serial line model feeding the receiver.
// Assumes: One strobe every other clock, LSB first.
// Notes: Data is inverted between bits so stale values never match.
module bsrx_line (
	input wire logic clk,
	output logic rx_data,
	output logic rx_bit_stb
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_data = 1'b0;
		rx_bit_stb = 1'b0;
	end
	// Shifts one character out, holding each bit for its strobe edge.
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			rx_data <= b[i];
			rx_bit_stb <= 1'b1;
			@(posedge clk);
			rx_bit_stb <= 1'b0;
			rx_data <= ~b[i];
		end
	endtask
endmodule

// ### tb/bsrx_top_tb.sv
// Purpose: Self-checking bench for the byte-sync receive control.
// Assumes: Channel B, sync character 8'h16, carrier dropped near the end.
// Notes: A queue models the character FIFO drained by the CPU and DMA sides.
module bsrx_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, wr_stb, rd_stb, dma_rd_stb, rx_data, rx_bit_stb;
	logic [3:0] addr;
	logic [7:0] wdata, rdata_q, dma_data_q, d;
	logic rdy_n_q, irq_n_q, dcd_n;
	logic [15:0] crc_m;
	logic [15:0] lfsr = 16'h4d0d;
	logic [7:0] q[$];
	int n_errors = 0;
	int compares = 0;
	bsrx_top uut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
		.rx_data(rx_data), .rx_bit_stb(rx_bit_stb), .dcd_n(dcd_n),
		.dma_rd_stb(dma_rd_stb), .dma_data_q(dma_data_q),
		.rdy_n_q(rdy_n_q), .irq_n_q(irq_n_q));
	bsrx_line line (.clk(clk), .rx_data(rx_data), .rx_bit_stb(rx_bit_stb));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction
	// Reflected CRC-16 over one byte, LSB first, as the checker shifts it.
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c >> 1) ^ ((c[0] ^ b[i]) ? 16'ha001 : 16'h0000);
		return c;
	endfunction
	// Steps just past an edge so design updates have landed.
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		tick();
		wr_stb <= 1'b0;
		tick();
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		addr <= a;
		rd_stb <= 1'b1;
		tick();
		rd_stb <= 1'b0;
		chk(rdata_q, exp);
		tick();
	endtask
	task automatic pop_dma();
		for (int k = 0; k < 40 && rdy_n_q !== 1'b0; k++) tick();
		chk({7'h00, rdy_n_q}, 8'h00);
		dma_rd_stb <= 1'b1;
		tick();
		dma_rd_stb <= 1'b0;
		chk(dma_data_q, q.pop_front());
		tick();
	endtask
	// Sends a character; a full model FIFO drops it as overrun.
	task automatic feed(input logic [7:0] v);
		line.send(v);
		if (q.size() < 32) q.push_back(v);
		tick();
	endtask
	task automatic tally_and_finish();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		reset_n = 1'b0;
		{wr_stb, rd_stb, dma_rd_stb} = 3'h0;
		dcd_n = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		chk({6'h00, rdy_n_q, irq_n_q}, 8'h03);
		// The carrier sampler needs one live edge before status is read.
		tick();
		rdc(4'h0, 8'h18);
		rdc(4'h5, 8'h00);
		wr(4'h0, 8'h18);
		wr(4'h6, 8'h16);
		wr(4'h7, 8'h16);
		wr(4'h2, 8'ha1);
		wr(4'h0, 8'h10);
		wr(4'h1, 8'h8d);
		wr(4'h3, 8'hf3);
		line.send(8'h16);
		line.send(8'h55);
		tick();
		rdc(4'h0, 8'h18);
		line.send(8'h16);
		line.send(8'h16);
		tick();
		rdc(4'h0, 8'h08);
		d = rnd() | 8'h80;
		feed(d);
		chk({7'h00, irq_n_q}, 8'h00);
		rdc(4'h2, 8'had);
		rdc(4'h8, q.pop_front());
		tick();
		chk({7'h00, irq_n_q}, 8'h01);
		repeat (3) begin
			feed(rnd());
			chk({7'h00, irq_n_q}, 8'h01);
			pop_dma();
		end
		wr(4'h0, 8'h20);
		feed(rnd());
		chk({7'h00, irq_n_q}, 8'h00);
		rdc(4'h8, q.pop_front());
		repeat (33) feed(rnd());
		chk({7'h00, irq_n_q}, 8'h00);
		rdc(4'h1, 8'h20);
		repeat (32) pop_dma();
		rdc(4'h0, 8'h0a);
		rdc(4'h1, 8'h20);
		wr(4'h0, 8'h30);
		rdc(4'h1, 8'h00);
		chk({7'h00, irq_n_q}, 8'h01);
		// CRC over STX and one data byte, then the two check bytes.
		d = rnd();
		wr(4'h0, 8'h40);
		feed(8'h02);
		wr(4'h3, 8'heb);
		feed(d);
		crc_m = crc_byte(crc_byte(16'h0000, 8'h02), d);
		feed(crc_m[7:0]);
		feed(crc_m[15:8]);
		rdc(4'h1, (crc_m != 16'h0000) ? 8'h40 : 8'h00);
		feed(rnd());
		feed(rnd());
		rdc(4'h1, 8'h00);
		repeat (6) pop_dma();
		// Carrier loss: status interrupt, and auto enables stop the line.
		dcd_n <= 1'b1;
		tick();
		tick();
		chk({7'h00, irq_n_q}, 8'h00);
		rdc(4'h2, 8'hab);
		line.send(rnd());
		tick();
		rdc(4'h0, 8'h02);
		// Termination: modes redefined, then the receiver switched off.
		wr(4'h0, 8'h10);
		wr(4'h1, 8'h00);
		wr(4'h3, 8'h00);
		dcd_n <= 1'b0;
		line.send(rnd());
		tick();
		rdc(4'h0, 8'h08);
		tally_and_finish();
	end
	// Cuts a hang short; the run needs well under a quarter of this.
	initial begin
		#200us;
		n_errors++;
		tally_and_finish();
	end
endmodule
bind bsrx_top bsrx_top_asserts chk_i (.clk(clk), .reset_n(reset_n),
	.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rdata_q(rdata_q), .rx_data(rx_data), .rx_bit_stb(rx_bit_stb),
	.dcd_n(dcd_n), .dma_rd_stb(dma_rd_stb), .dma_data_q(dma_data_q),
	.rdy_n_q(rdy_n_q), .irq_n_q(irq_n_q));
